// [pkg/rxc_cfg.svh]
// Register map, field positions and timing figures of the receiver control block
`ifndef RXC_CFG_SVH
`define RXC_CFG_SVH
`define RXC_REG_RX_CFG 7'h18
`define RXC_REG_LO_CFG 7'h19
`define RXC_REG_RX_STATE 7'h1A
`define RXC_REG_LO_STATE 7'h22
`define RXC_REG_SEQ_CMD 7'h2A
`define RXC_REG_MAN_RX_EN 7'h2B
`define RXC_REG_MAN_GAIN12 7'h2C
`define RXC_REG_MAN_GAIN34 7'h2D
`define RXC_REG_MAN_STAGE 7'h2E
`define RXC_REG_MAN_MULT 7'h2F
`define RXC_REG_CONV_CTRL 7'h30
`define RXC_REG_CONV_RESULT 7'h31
`define RXC_REG_RX_MODE 7'h40
`define RXC_REG_LO_MODE 7'h70
`define RXC_RX_MODE_BYTES 7'h03
`define RXC_SEQ_EN_BIT 7
`define RXC_CONV_DONE_BIT 0
`define RXC_CONV_START_BIT 4
`define RXC_CONV_CLKEN_BIT 5
`define RXC_CONV_POWER_BIT 6
`define RXC_CONV_RATE_BIT 7
`define RXC_CMD_LO_RST_BIT 3
`define RXC_CMD_LO_ADV_BIT 2
`define RXC_CMD_RX_RST_BIT 1
`define RXC_CMD_RX_ADV_BIT 0
`define RXC_LO_BUF_BIT 6
`define RXC_LO_BPF_BIT 7
`define RXC_RX_SPLIT1_BIT 4
`define RXC_RX_SPLIT12_BIT 5
`define RXC_RX_SPLIT34_BIT 6
`define RXC_STAGE_LNA_BIT 0
`define RXC_STAGE_MIX_BIT 1
`define RXC_STAGE_IF_BIT 2
`define RXC_SPI_HDR_LAST 5'h0F
`define RXC_SPI_FRAME_LAST 5'h17
`define RXC_CLK_HZ 50000000
`define RXC_CONV_FAST_HZ 2000000
`define RXC_CONV_SLOW_HZ 250000
`endif

// [pkg/rxc_pkg.sv]
// Types shared by the receiver control block
package rxc_pkg;
  typedef enum logic [1:0] {
    RXC_SLEEP = 2'b00,
    RXC_READY = 2'b01,
    RXC_ACTIVE = 2'b11
  } rxc_band_t;
  typedef enum logic [1:0] {
    RXC_SPI_HDR = 2'b00,
    RXC_SPI_WR = 2'b01,
    RXC_SPI_RD = 2'b10,
    RXC_SPI_END = 2'b11
  } rxc_spi_t;
endpackage : rxc_pkg

// [hdl/rxc_seq.sv]
// Sequencer state pointer: restart, step and wrap within the loop depth
`timescale 1ns/1ps
module rxc_seq #(
  parameter int STATES = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic [3:0] depth_i,
  input wire logic restart_i,
  input wire logic step_i,
  output logic [4:0] ptr_o
);
  if (STATES != 16) $error("rxc_seq serves exactly 16 state slots");

  logic [4:0] last;
  assign last = {1'b0, depth_i} + 5'h01;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr_o <= 5'h00;
    end else if (enable_i) begin
      if (restart_i) begin
        ptr_o <= 5'h00; // see R22
      end else if (step_i) begin
        // Also catches a depth lowered under a running pointer
        ptr_o <= (ptr_o >= last) ? 5'h01 : ptr_o + 5'h01; // see R18 see R19 see R23
      end
    end
  end

  chk_restart_zero: assert property (@(posedge clk_i) disable iff (rst_i) // see R22
    enable_i && restart_i |=> ptr_o == 5'h00)
    else $error("restart did not return pointer to zero");
  chk_step_wrap: assert property (@(posedge clk_i) disable iff (rst_i) // see R23
    enable_i && !restart_i && step_i && ptr_o >= last |=> ptr_o == 5'h01)
    else $error("step at loop end did not wrap to one");
  chk_step_next: assert property (@(posedge clk_i) disable iff (rst_i) // see R18
    enable_i && !restart_i && step_i && ptr_o < last |=> ptr_o == $past(ptr_o) + 5'h01)
    else $error("step did not advance by one");
  chk_pins_ignored: assert property (@(posedge clk_i) disable iff (rst_i) // see R12
    !enable_i |=> $stable(ptr_o))
    else $error("pointer moved while sequencer disabled");
endmodule : rxc_seq

// [hdl/rxc_adc.sv]
// Temperature converter sequencing: clock divider, conversion count, result capture
`timescale 1ns/1ps
`include "rxc_cfg.svh"
module rxc_adc #(
  parameter int CONV_CLOCKS = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic power_i,
  input wire logic clk_en_i,
  input wire logic slow_i,
  input wire logic start_i,
  input wire logic [7:0] sample_i,
  output logic busy_o,
  output logic done_o,
  output logic finish_o,
  output logic [7:0] result_o
);
  if (CONV_CLOCKS < 1 || CONV_CLOCKS > 255) $error("rxc_adc CONV_CLOCKS out of range");
  localparam logic [7:0] FAST_DIV = 8'(`RXC_CLK_HZ / `RXC_CONV_FAST_HZ);
  localparam logic [7:0] SLOW_DIV = 8'(`RXC_CLK_HZ / `RXC_CONV_SLOW_HZ);
  localparam logic [7:0] LAST_CLOCK = 8'(CONV_CLOCKS - 1);

  logic [7:0] div;
  logic [7:0] clocks;
  logic tick;
  // Converter clock only runs while both gate and power are on
  assign tick = busy_o && power_i && clk_en_i && div == (slow_i ? SLOW_DIV : FAST_DIV) - 8'h01;

  always_ff @(posedge clk_i) begin
    if (rst_i || !busy_o) begin
      div <= 8'h00;
    end else if (power_i && clk_en_i) begin // see R3 see R4
      div <= tick ? 8'h00 : div + 8'h01; // see R5
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
      clocks <= 8'h00;
      finish_o <= 1'b0;
      done_o <= 1'b0;
      result_o <= 8'h00;
    end else begin
      finish_o <= 1'b0;
      if (start_i && !busy_o) begin
        busy_o <= 1'b1; // see R2
        clocks <= 8'h00;
        done_o <= 1'b0; // see R24
      end else if (tick) begin
        clocks <= clocks + 8'h01;
        if (clocks == LAST_CLOCK) begin
          busy_o <= 1'b0;
          finish_o <= 1'b1;
          done_o <= 1'b1; // see R1
          result_o <= sample_i; // see R7
        end
      end
    end
  end

  sequence s_finish;
    finish_o ##0 !busy_o;
  endsequence
  chk_done_cleared: assert property (@(posedge clk_i) disable iff (rst_i) // see R24
    start_i && !busy_o |=> !done_o && busy_o)
    else $error("start did not clear done flag");
  chk_result_held: assert property (@(posedge clk_i) disable iff (rst_i) // see R7
    s_finish |-> done_o && result_o == $past(sample_i))
    else $error("result not captured with done");
  chk_no_clock_idle: assert property (@(posedge clk_i) disable iff (rst_i) // see R3
    busy_o && !clk_en_i |=> clocks == $past(clocks) && busy_o)
    else $error("conversion advanced with clock gated off");
endmodule : rxc_adc

// [hdl/rxc_top.sv]
// Receiver control: serial register port, two sequencers, manual mode and converter
//
// Notes on behaviour
// R1: Control bit zero reads conversion finished
// R2: Writing start bit begins one conversion
// R3: Bit five gates the converter clock
// R4: Bit six powers the converter
// R5: Bit seven picks 2 MHz or 250 kHz
// R6: Host polls done before reading result
// R7: Eight-bit temperature result held in register
// R8: Both sequencers off selects manual registers
// R9: Manual multiplier byte uses mode layout
// R10: Manual channel needs all stage enables
// R11: Sequencer channel enable drives whole chain
// R12: Pins ignored while sequencers are disabled
// R13: Multiplier mode: buffer, three bands, filter
// R14: Band bits decode sleep, ready, active
// R15: Receiver mode: channels, splitters, gains
// R16: Multiplier sequencer: 16 slots, 16 modes
// R17: Receiver sequencer: 16 slots, 16 modes
// R18: Pointer steps ascending up to depth plus one
// R19: Loop length is depth plus one
// R20: Filter bit high selects low corner
// R21: Host programs six sweep settings
// R22: Restart returns pointer to state zero
// R23: Step at loop end wraps to one
// R24: New start clears done until stored
`timescale 1ns/1ps
`include "rxc_cfg.svh"
module rxc_top #(
  parameter int CONV_CLOCKS = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_sclk_i,
  input wire logic spi_sdio_i,
  output logic spi_sdio_o,
  output logic spi_sdio_oe_o,
  input wire logic receiver_restart_pin_i,
  input wire logic receiver_step_pin_i,
  input wire logic lo_restart_pin_i,
  input wire logic lo_step_pin_i,
  input wire logic [7:0] temp_code_i,
  output logic lo_buffer_en_o,
  output rxc_pkg::rxc_band_t lo_low_band_o,
  output rxc_pkg::rxc_band_t lo_mid_band_o,
  output rxc_pkg::rxc_band_t lo_high_band_o,
  output logic band_pass_filter_o,
  output logic [3:0] rx_channel_on_o,
  output logic rx_splitter_first_o,
  output logic rx_splitter_12_o,
  output logic rx_splitter_34_o,
  output logic [15:0] rx_gain_o,
  output logic conv_power_o,
  output logic conv_clk_en_o,
  output logic converter_rate_select_o
);
  import rxc_pkg::*;

  // Two-flop synchronisers; stage one is read by stage two only
  localparam int SW = 15;
  logic [SW-1:0] sync_a;
  logic [SW-1:0] sync_b;
  logic [SW-1:0] sync_c;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_a <= {SW{1'b0}};
      sync_b <= {SW{1'b0}};
      sync_c <= {SW{1'b0}};
    end else begin
      sync_a <= {temp_code_i, lo_step_pin_i, lo_restart_pin_i, receiver_step_pin_i,
                 receiver_restart_pin_i, spi_sdio_i, spi_sclk_i, ~spi_cs_n_i};
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  logic cs_act;
  logic sclk_rise;
  logic sclk_fall;
  logic sdio_s;
  logic [3:0] pin_rise;
  logic [7:0] temp_s;
  assign cs_act = sync_b[0];
  assign sclk_rise = sync_b[1] && !sync_c[1];
  assign sclk_fall = !sync_b[1] && sync_c[1];
  assign sdio_s = sync_b[2];
  assign pin_rise = sync_b[6:3] & ~sync_c[6:3];
  assign temp_s = sync_b[14:7];

  // Serial frame: read flag, 15 address bits, 8 data bits, MSB first
  rxc_spi_t spi_phase;
  logic [4:0] bit_cnt;
  logic [14:0] shreg;
  logic [14:0] spi_addr;
  logic [7:0] out_byte;
  logic spi_wr;
  logic [7:0] spi_wr_data;
  logic [7:0] regs [0:127];
  logic conv_busy;
  logic conv_done;
  logic conv_finish;
  logic [7:0] conv_result;
  logic conv_start;

  function automatic logic [7:0] read_byte(input logic [14:0] a);
    logic [6:0] lo;
    lo = a[6:0];
    if (a[14:7] != 8'h00) begin
      read_byte = 8'h00;
    end else if (lo == `RXC_REG_CONV_CTRL) begin
      read_byte = {regs[lo][7:5], conv_start, 3'h0, conv_done}; // see R1 see R2
    end else if (lo == `RXC_REG_CONV_RESULT) begin
      read_byte = conv_result; // see R6 see R7
    end else if (lo == `RXC_REG_SEQ_CMD) begin
      read_byte = 8'h00;
    end else begin
      read_byte = regs[lo];
    end
  endfunction : read_byte

  assign spi_wr = cs_act && sclk_rise && spi_phase == RXC_SPI_WR
    && bit_cnt == `RXC_SPI_FRAME_LAST;
  assign spi_wr_data = {shreg[6:0], sdio_s};

  always_ff @(posedge clk_i) begin
    if (rst_i || !cs_act) begin
      spi_phase <= RXC_SPI_HDR;
      bit_cnt <= 5'h00;
      shreg <= 15'h0000;
      spi_addr <= 15'h0000;
      out_byte <= 8'h00;
    end else if (sclk_rise) begin
      shreg <= {shreg[13:0], sdio_s};
      bit_cnt <= bit_cnt + 5'h01;
      unique case (spi_phase)
        RXC_SPI_HDR: begin
          if (bit_cnt == `RXC_SPI_HDR_LAST) begin
            spi_addr <= {shreg[13:0], sdio_s};
            spi_phase <= shreg[14] ? RXC_SPI_RD : RXC_SPI_WR;
            out_byte <= read_byte({shreg[13:0], sdio_s});
          end
        end
        RXC_SPI_WR, RXC_SPI_RD: begin
          if (bit_cnt == `RXC_SPI_FRAME_LAST) begin
            spi_phase <= RXC_SPI_END;
          end
        end
        RXC_SPI_END: begin
          spi_phase <= RXC_SPI_END;
        end
      endcase
    end else if (sclk_fall && spi_phase == RXC_SPI_RD) begin
      out_byte <= {out_byte[6:0], 1'b0};
    end
  end

  // Read data changes on the falling edge so the host samples it on the next rise
  always_ff @(posedge clk_i) begin
    if (rst_i || !cs_act) begin
      spi_sdio_o <= 1'b0;
      spi_sdio_oe_o <= 1'b0;
    end else if (sclk_fall && spi_phase == RXC_SPI_RD) begin
      spi_sdio_o <= out_byte[7];
      spi_sdio_oe_o <= 1'b1;
    end else if (spi_phase != RXC_SPI_RD) begin
      spi_sdio_oe_o <= 1'b0;
    end
  end

  logic map_wr;
  logic [6:0] wa;
  assign wa = spi_addr[6:0];
  assign map_wr = spi_wr && spi_addr[14:7] == 8'h00;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 128; i++) begin
        regs[i] <= 8'h00;
      end
    end else if (map_wr && wa != `RXC_REG_SEQ_CMD && wa != `RXC_REG_CONV_RESULT) begin
      regs[wa] <= spi_wr_data; // see R16 see R17
    end
  end

  // Start bit stays set until the result lands; a start during a conversion is dropped
  logic conv_go;
  assign conv_go = map_wr && wa == `RXC_REG_CONV_CTRL && spi_wr_data[`RXC_CONV_START_BIT];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv_start <= 1'b0;
    end else if (conv_go && !conv_busy) begin
      conv_start <= 1'b1; // see R2
    end else if (conv_finish) begin
      conv_start <= 1'b0;
    end
  end

  logic [7:0] cc;
  assign cc = regs[`RXC_REG_CONV_CTRL];
  rxc_adc #(
    .CONV_CLOCKS(CONV_CLOCKS)
  ) u_adc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .power_i(cc[`RXC_CONV_POWER_BIT]),
    .clk_en_i(cc[`RXC_CONV_CLKEN_BIT]),
    .slow_i(cc[`RXC_CONV_RATE_BIT]),
    .start_i(conv_go),
    .sample_i(temp_s),
    .busy_o(conv_busy),
    .done_o(conv_done),
    .finish_o(conv_finish),
    .result_o(conv_result)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv_power_o <= 1'b0;
      conv_clk_en_o <= 1'b0;
      converter_rate_select_o <= 1'b0;
    end else begin
      conv_power_o <= cc[`RXC_CONV_POWER_BIT]; // see R4
      conv_clk_en_o <= cc[`RXC_CONV_CLKEN_BIT]; // see R3
      converter_rate_select_o <= cc[`RXC_CONV_RATE_BIT]; // see R5
    end
  end

  // Sequencers: pins and command-register strobes share the same restart/step path
  logic lo_sequencer_enable;
  logic receiver_sequencer_enable;
  logic manual;
  logic [7:0] cmd;
  logic [4:0] lo_ptr;
  logic [4:0] rx_ptr;
  assign lo_sequencer_enable = regs[`RXC_REG_LO_CFG][`RXC_SEQ_EN_BIT];
  assign receiver_sequencer_enable = regs[`RXC_REG_RX_CFG][`RXC_SEQ_EN_BIT];
  assign manual = !lo_sequencer_enable && !receiver_sequencer_enable; // see R8
  assign cmd = (map_wr && wa == `RXC_REG_SEQ_CMD) ? spi_wr_data : 8'h00;

  rxc_seq u_lo_seq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .enable_i(lo_sequencer_enable), // see R12
    .depth_i(regs[`RXC_REG_LO_CFG][3:0]),
    .restart_i(pin_rise[2] || cmd[`RXC_CMD_LO_RST_BIT]),
    .step_i(pin_rise[3] || cmd[`RXC_CMD_LO_ADV_BIT]),
    .ptr_o(lo_ptr)
  );

  rxc_seq u_rx_seq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .enable_i(receiver_sequencer_enable), // see R12
    .depth_i(regs[`RXC_REG_RX_CFG][3:0]),
    .restart_i(pin_rise[0] || cmd[`RXC_CMD_RX_RST_BIT]),
    .step_i(pin_rise[1] || cmd[`RXC_CMD_RX_ADV_BIT]),
    .ptr_o(rx_ptr)
  );

  // State s (1..16) sits in byte (s-1)/2, odd states in the upper nibble
  function automatic logic [3:0] slot_mode(input logic [6:0] base, input logic [4:0] ptr);
    logic [4:0] idx;
    logic [7:0] b;
    idx = ptr - 5'h01;
    b = regs[base + {3'h0, idx[4:1]}];
    if (ptr == 5'h00) begin
      slot_mode = 4'h0; // see R22
    end else begin
      slot_mode = idx[0] ? b[3:0] : b[7:4];
    end
  endfunction : slot_mode

  function automatic rxc_band_t band(input logic [1:0] f);
    unique case (f)
      2'b11: band = RXC_ACTIVE;
      2'b01: band = RXC_READY;
      default: band = RXC_SLEEP;
    endcase
  endfunction : band

  logic [3:0] lo_mode;
  logic [3:0] rx_mode;
  logic [6:0] rx_base;
  logic [7:0] next_lo;
  logic [7:0] next_en;
  logic [7:0] next_stage;
  logic [15:0] next_gain;
  assign lo_mode = slot_mode(`RXC_REG_LO_STATE, lo_ptr); // see R16
  assign rx_mode = slot_mode(`RXC_REG_RX_STATE, rx_ptr); // see R17
  assign rx_base = `RXC_REG_RX_MODE + 7'(rx_mode * `RXC_RX_MODE_BYTES);
  assign next_lo = manual ? regs[`RXC_REG_MAN_MULT]
                          : regs[`RXC_REG_LO_MODE + {3'h0, lo_mode}]; // see R9
  assign next_en = manual ? regs[`RXC_REG_MAN_RX_EN] : regs[rx_base]; // see R15
  assign next_gain = manual ? {regs[`RXC_REG_MAN_GAIN34], regs[`RXC_REG_MAN_GAIN12]}
                            : {regs[rx_base + 7'h02], regs[rx_base + 7'h01]};
  // Sequencer modes cannot reach the stage enables, so they read as all on
  assign next_stage = manual ? regs[`RXC_REG_MAN_STAGE] : 8'hFF; // see R11

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lo_buffer_en_o <= 1'b0;
      lo_low_band_o <= RXC_SLEEP;
      lo_mid_band_o <= RXC_SLEEP;
      lo_high_band_o <= RXC_SLEEP;
      band_pass_filter_o <= 1'b0;
    end else begin
      lo_buffer_en_o <= next_lo[`RXC_LO_BUF_BIT]; // see R13
      lo_low_band_o <= band(next_lo[1:0]); // see R14
      lo_mid_band_o <= band(next_lo[3:2]);
      lo_high_band_o <= band(next_lo[5:4]);
      band_pass_filter_o <= next_lo[`RXC_LO_BPF_BIT]; // see R20
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_channel_on_o <= 4'h0;
      rx_splitter_first_o <= 1'b0;
      rx_splitter_12_o <= 1'b0;
      rx_splitter_34_o <= 1'b0;
      rx_gain_o <= 16'h0000;
    end else begin
      rx_channel_on_o <= next_en[3:0] & {4{next_stage[`RXC_STAGE_LNA_BIT]
        & next_stage[`RXC_STAGE_MIX_BIT] & next_stage[`RXC_STAGE_IF_BIT]}}; // see R10 see R11
      rx_splitter_first_o <= next_en[`RXC_RX_SPLIT1_BIT]; // see R15
      rx_splitter_12_o <= next_en[`RXC_RX_SPLIT12_BIT];
      rx_splitter_34_o <= next_en[`RXC_RX_SPLIT34_BIT];
      rx_gain_o <= next_gain;
    end
  end

  logic [7:0] man_stage;
  assign man_stage = regs[`RXC_REG_MAN_STAGE];
  chk_manual_mult: assert property (@(posedge clk_i) disable iff (rst_i) // see R9
    manual |=> band_pass_filter_o == $past(regs[`RXC_REG_MAN_MULT][`RXC_LO_BPF_BIT]))
    else $error("manual filter bit not applied");
  chk_manual_chain: assert property (@(posedge clk_i) disable iff (rst_i) // see R10
    manual && !man_stage[`RXC_STAGE_MIX_BIT] |=> rx_channel_on_o == 4'h0)
    else $error("channel on without mixer enable in manual mode");
  chk_seq_chain: assert property (@(posedge clk_i) disable iff (rst_i) // see R11
    !manual |=> rx_channel_on_o == $past(next_en[3:0]))
    else $error("sequencer channel enable not applied to whole chain");
  chk_restart_mode: assert property (@(posedge clk_i) disable iff (rst_i) // see R22
    !manual && lo_ptr == 5'h00
    |=> lo_buffer_en_o == $past(regs[`RXC_REG_LO_MODE][`RXC_LO_BUF_BIT]))
    else $error("state zero did not apply mode zero");
  chk_band_sleep: assert property (@(posedge clk_i) disable iff (rst_i) // see R14
    next_lo[1:0] == 2'b10 |=> lo_low_band_o == RXC_SLEEP)
    else $error("band with only active bit not asleep");
endmodule : rxc_top

// [tb/rxc_host.sv]
// Host side model: serial register master and sequencer pin driver
`timescale 1ns/1ps
module rxc_host (
  input wire logic clk_i,
  input wire logic sdio_i,
  input wire logic sdio_oe_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic sdio_o,
  output logic [3:0] pins_o
);
  logic drv = 1'b1;
  logic bit_q = 1'b0;
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    pins_o = 4'h0;
  end
  // Released line shows the inverse of the last bit, never a stale copy
  assign sdio_o = sdio_oe_i ? sdio_i : (drv ? bit_q : ~bit_q);
  // One 24-bit frame; read bits are taken from the line just before each rise
  task automatic frame(input logic rd, input logic [14:0] a, input logic [7:0] d,
                       output logic [7:0] q);
    logic [23:0] w;
    w = {rd, a, d};
    q = 8'h00;
    @(negedge clk_i);
    cs_n_o = 1'b0;
    repeat (4) @(negedge clk_i);
    for (int i = 0; i < 24; i++) begin
      sclk_o = 1'b0;
      drv = !(rd && i >= 16);
      if (drv) bit_q = w[23-i];
      repeat (4) @(negedge clk_i);
      // Line only carries read data while the block drives it
      if (!drv) q = {q[6:0], sdio_o};
      sclk_o = 1'b1;
      repeat (4) @(negedge clk_i);
    end
    sclk_o = 1'b0;
    repeat (4) @(negedge clk_i);
    cs_n_o = 1'b1;
    drv = 1'b1;
    repeat (4) @(negedge clk_i);
  endtask : frame
  // Pin order: 0 rx restart, 1 rx step, 2 lo restart, 3 lo step
  task automatic pulse(input logic [3:0] which);
    @(negedge clk_i);
    pins_o = which;
    repeat (3) @(negedge clk_i);
    pins_o = 4'h0;
    repeat (5) @(negedge clk_i);
  endtask : pulse
endmodule : rxc_host

// [tb/tb_top.sv]
// Self-checking bench of the receiver control block
`timescale 1ns/1ps
module tb_top;
  import rxc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] temp_code = 8'h00;
  logic cs_n, sclk, sdio_in, sdio_out, sdio_oe, lo_buf, band_pass_filter, sp1, sp12, sp34, c_pwr, c_clk, c_rate;
  logic [3:0] pins;
  logic [3:0] ch_on;
  logic [15:0] gain;
  rxc_band_t lo_low, lo_mid, lo_high;
  int fail_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #10 clk_i = ~clk_i;
  rxc_host i_rxc_host (.clk_i(clk_i), .sdio_i(sdio_out), .sdio_oe_i(sdio_oe), .cs_n_o(cs_n),
    .sclk_o(sclk), .sdio_o(sdio_in), .pins_o(pins));
  rxc_top #(.CONV_CLOCKS(1)) i_rxc_top (.clk_i(clk_i), .rst_i(rst_i), .spi_cs_n_i(cs_n),
    .spi_sclk_i(sclk), .spi_sdio_i(sdio_in), .spi_sdio_o(sdio_out), .spi_sdio_oe_o(sdio_oe),
    .receiver_restart_pin_i(pins[0]), .receiver_step_pin_i(pins[1]),
    .lo_restart_pin_i(pins[2]), .lo_step_pin_i(pins[3]), .temp_code_i(temp_code),
    .lo_buffer_en_o(lo_buf), .lo_low_band_o(lo_low), .lo_mid_band_o(lo_mid),
    .lo_high_band_o(lo_high), .band_pass_filter_o(band_pass_filter), .rx_channel_on_o(ch_on),
    .rx_splitter_first_o(sp1), .rx_splitter_12_o(sp12), .rx_splitter_34_o(sp34),
    .rx_gain_o(gain), .conv_power_o(c_pwr), .conv_clk_en_o(c_clk),
    .converter_rate_select_o(c_rate));
  task automatic end_of_test();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test
  // Whole run needs about 10k cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      fail_count = fail_count + 1;
      end_of_test();
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic [7:0] q;
    i_rxc_host.frame(1'b0, a, d, q);
  endtask : wr
  task automatic rdc(input logic [14:0] a, input logic [7:0] exp, input string what);
    logic [7:0] q;
    i_rxc_host.frame(1'b1, a, 8'h00, q);
    chk(what, {8'h00, exp}, {8'h00, q});
  endtask : rdc
  // Only the upper band bit alone decodes as sleep
  function automatic logic [7:0] exp_lo(input logic [7:0] v);
    logic [7:0] e;
    e = v;
    for (int b = 0; b < 6; b += 2) begin
      if (v[b+:2] == 2'b10) e[b+:2] = 2'b00;
    end
    return e;
  endfunction : exp_lo
  function automatic logic [15:0] lo_now();
    return {8'h00, band_pass_filter, lo_buf, lo_high, lo_mid, lo_low};
  endfunction : lo_now
  task automatic t_reset();
    wr(15'h7F2F, 8'hFF);
    rdc(15'h002F, 8'h00, "manual mult");
    rdc(15'h0030, 8'h00, "conv ctrl");
    rdc(15'h0031, 8'h00, "conv result");
    rdc(15'h002A, 8'h00, "seq cmd");
    rdc(15'h4030, 8'h00, "unmapped");
    chk("lo outputs", 16'h0000, lo_now());
  endtask : t_reset
  task automatic t_manual_lo();
    logic [7:0] v[5] = '{8'h7A, 8'hEE, 8'h6B, 8'h45, 8'hA2};
    for (int i = 0; i < 5; i++) begin
      wr(15'h002F, v[i]);
      chk("manual lo", {8'h00, exp_lo(v[i])}, lo_now());
      rdc(15'h002F, v[i], "manual mult rb");
    end
  endtask : t_manual_lo
  task automatic t_manual_rx();
    wr(15'h002C, 8'h21);
    wr(15'h002D, 8'h43);
    wr(15'h002B, 8'h7F);
    wr(15'h002E, 8'h03);
    chk("ch no if", 16'h0000, {12'h000, ch_on});
    chk("splitters", 16'h0007, {13'h0000, sp34, sp12, sp1});
    chk("gains", 16'h4321, gain);
    wr(15'h002E, 8'h07);
    chk("ch all stages", 16'h000F, {12'h000, ch_on});
  endtask : t_manual_rx
  task automatic t_pins_idle();
    logic [15:0] lo;
    lo = lo_now();
    i_rxc_host.pulse(4'hF);
    chk("lo idle pins", lo, lo_now());
    chk("ch idle pins", 16'h000F, {12'h000, ch_on});
  endtask : t_pins_idle
  task automatic t_converter();
    logic [7:0] want[2] = '{8'hA5, 8'h3C};
    logic [7:0] q;
    temp_code = 8'hA5;
    wr(15'h0030, 8'h50);
    repeat (300) @(negedge clk_i);
    rdc(15'h0030, 8'h50, "gated conv");
    chk("conv pins", 16'h0001, {13'h0000, c_rate, c_clk, c_pwr});
    wr(15'h0030, 8'h70);
    for (int k = 0; k < 2; k++) begin
      if (k == 1) begin
        temp_code = 8'h3C;
        wr(15'h0030, 8'hF0);
        rdc(15'h0030, 8'hF0, "done cleared");
        chk("slow pins", 16'h0007, {13'h0000, c_rate, c_clk, c_pwr});
      end
      q = 8'h00;
      for (int n = 0; n < 10 && !q[0]; n++) begin
        i_rxc_host.frame(1'b1, 15'h0030, 8'h00, q);
      end
      chk("conv done", {8'h00, k ? 8'hE1 : 8'h61}, {8'h00, q});
      rdc(15'h0031, want[k], "result");
    end
    wr(15'h0031, 8'h00);
    rdc(15'h0031, 8'h3C, "result ro");
  endtask : t_converter
  task automatic t_sequencers();
    logic [7:0] seq[5] = '{8'hC7, 8'h1D, 8'hB3, 8'hC7, 8'h45};
    wr(15'h0070, 8'h45);
    wr(15'h0073, 8'hC7);
    wr(15'h0075, 8'h1D);
    wr(15'h0079, 8'hB3);
    wr(15'h0022, 8'h35);
    wr(15'h0023, 8'h90);
    wr(15'h0019, 8'h82);
    chk("lo state0", 16'h0045, lo_now());
    for (int i = 0; i < 5; i++) begin
      i_rxc_host.pulse(i == 4 ? 4'h4 : 4'h8);
      chk("lo step", {8'h00, exp_lo(seq[i])}, lo_now());
    end
    wr(15'h002E, 8'h00);
    wr(15'h0046, 8'h71);
    wr(15'h0047, 8'h2A);
    wr(15'h0048, 8'h0F);
    wr(15'h001A, 8'h20);
    wr(15'h0018, 8'h80);
    for (int i = 0; i < 2; i++) begin
      i_rxc_host.pulse(4'h2);
      chk("rx ch", 16'h0001, {12'h000, ch_on});
      chk("rx split", 16'h0007, {13'h0000, sp34, sp12, sp1});
      chk("rx gain", 16'h0F2A, gain);
    end
    i_rxc_host.pulse(4'h1);
    chk("rx restart", 16'h0000, {12'h000, ch_on});
    wr(15'h002A, 8'h05);
    chk("lo cmd step", 16'h00C7, lo_now());
    chk("rx cmd step", 16'h0001, {12'h000, ch_on});
    wr(15'h002A, 8'h0A);
    chk("lo cmd restart", 16'h0045, lo_now());
    chk("rx cmd restart", 16'h0000, {12'h000, ch_on});
  endtask : t_sequencers
  initial begin
    repeat (12) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    t_reset();
    t_manual_lo();
    t_manual_rx();
    t_pins_idle();
    t_converter();
    t_sequencers();
    end_of_test();
  end
endmodule : tb_top
